/* File: design/adcsc_control.sv */
// Purpose: Converter clock, sample phases and conversion sequence control.
// Assumes: APB slave with one wait state; analog front end answers compare at once.
// Notes:   Result justification, freeze and wait behaviour are not present.
//
// Notes on behaviour
// R1: Writing the clock/resolution register aborts any sequence and starts a new one.
// R2: Writing the sequence register restarts and clears sequence and conversion flags.
// R3: Resolution bit zero gives 8-bit conversion, one gives 10-bit.
// R4: An 8-bit conversion takes fewer converter clocks than a 10-bit one.
// R5: Final sample lasts 2, 4, 8 or 16 converter clocks per its field.
// R6: Final sample connects the input directly, after buffered sample and transfer.
// R7: Bus clock divided by a modulus counter of prescale value plus one.
// R8: Prescaler output divided by two more to form the converter clock.
// R9: Prescale field resets to one, giving a quarter of the bus clock.
// R10: Software keeps the converter clock between 500 kHz and 2 MHz.
// R11: Sequence length is four, one with short bit, eight with long bit.
// R12: Long bit at sequence register bit 6, short bit at third register bit 3.
// R13: Outside FIFO mode result n goes to result register n.
// R14: FIFO mode writes consecutive registers across sequences, wrapping after the last.
// R15: Scan clear stops after a sequence; scan set starts the next at once.
// R16: Single channel repeats the code; multi channel increments it each conversion.
// R17: Incremented channel code wraps from seven to zero.
// R18: Result pointer clears at reset and at start and end of non-FIFO sequences.
// R19: A restart reloads the prescale and phase counters from zero.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adcsc_control (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Interrupt
    output var  logic        irq,
    // Analog front end
    input  wire logic        afe_compare_above,
    output var  logic [2:0]  afe_channel,
    output var  logic        afe_special,
    output var  logic        afe_buffered_sample,
    output var  logic        afe_transfer,
    output var  logic        afe_direct_sample,
    output var  logic [9:0]  afe_dac_code
);
    adcsc_pkg::adcsc_state_e st_reg, st_next;
    logic [7:0] ctrl_three_reg, clock_res_reg, seq_ctrl_reg;
    logic [1:0] irq_status_reg, irq_mask_reg;
    logic [7:0] ccf_reg;
    logic       scf_reg;
    logic [4:0] phase_cnt_reg;
    logic [3:0] bit_idx_reg;
    logic [2:0] conv_cnt_reg, ptr_reg;
    logic [9:0] mem_rdata;
    logic       tick;

    // Bus decode.
    wire access_first = psel & penable & ~pready;
    wire wr_fire      = psel & penable & pready & pwrite;
    wire sel_c3  = (paddr == adcsc_pkg::OFS_CTRL_THREE);
    wire sel_cr  = (paddr == adcsc_pkg::OFS_CLOCK_RES);
    wire sel_sq  = (paddr == adcsc_pkg::OFS_SEQ_CTRL);
    wire sel_st  = (paddr == adcsc_pkg::OFS_STATUS);
    wire sel_is  = (paddr == adcsc_pkg::OFS_IRQ_STATUS);
    wire sel_im  = (paddr == adcsc_pkg::OFS_IRQ_MASK);
    wire sel_res = (paddr[7:5] == adcsc_pkg::RESULT_PAGE) && (paddr[1:0] == 2'h0);
    wire mapped  = sel_c3 | sel_cr | sel_sq | sel_st | sel_is | sel_im | sel_res;
    wire wr_clock_res = wr_fire & sel_cr;
    wire wr_seq       = wr_fire & sel_sq;
    wire restart      = wr_clock_res | wr_seq; // see R1 see R2

    // Configuration fields.
    wire       fifo_mode  = ctrl_three_reg[adcsc_pkg::CT3_FIFO];
    wire       len_one    = ctrl_three_reg[adcsc_pkg::CT3_LENGTH_ONE]; // see R12
    wire       len_eight  = seq_ctrl_reg[adcsc_pkg::SQ_LENGTH_EIGHT]; // see R12
    wire       scan_mode  = seq_ctrl_reg[adcsc_pkg::SQ_SCAN];
    wire       multi_sel  = seq_ctrl_reg[adcsc_pkg::SQ_MULTI];
    wire       res_ten    = clock_res_reg[adcsc_pkg::CR_RESOLUTION];
    wire [1:0] smp_sel    = clock_res_reg[adcsc_pkg::CR_SMP_LSB +: 2];
    wire [4:0] prescale   = clock_res_reg[4:0];
    wire [7:0] seq_next   = wr_seq ? (pwdata[7:0] & adcsc_pkg::SEQ_CTRL_MASK) : seq_ctrl_reg;
    wire [2:0] seq_last   = len_eight ? adcsc_pkg::LAST_OF_EIGHT :
                            len_one   ? adcsc_pkg::LAST_OF_ONE : adcsc_pkg::LAST_OF_FOUR; // see R11
    wire [3:0] bit_low    = res_ten ? adcsc_pkg::BIT_LOW_TEN : adcsc_pkg::BIT_LOW_EIGHT; // see R3 see R4
    wire [4:0] final_last = (adcsc_pkg::FINAL_BASE_TICKS << smp_sel) - 5'h01; // see R5
    wire [4:0] phase_last = (st_reg == adcsc_pkg::ST_BUF)  ? adcsc_pkg::BUF_SAMPLE_TICKS - 5'h01 :
                            (st_reg == adcsc_pkg::ST_XFER) ? adcsc_pkg::TRANSFER_TICKS - 5'h01 :
                            final_last;

    // Sequencing events; a restart in the same cycle aborts them.
    wire in_phase   = (st_reg == adcsc_pkg::ST_BUF) | (st_reg == adcsc_pkg::ST_XFER) |
                      (st_reg == adcsc_pkg::ST_FINAL);
    wire phase_done = tick & in_phase & (phase_cnt_reg == phase_last);
    wire conv_done  = tick & (st_reg == adcsc_pkg::ST_CONV) & (bit_idx_reg == bit_low) & ~restart;
    wire seq_done   = conv_done & (conv_cnt_reg == seq_last);

    // Successive approximation step.
    wire [9:0] bit_mask    = 10'h001 << bit_idx_reg;
    wire [9:0] dac_decided = afe_compare_above ? afe_dac_code : (afe_dac_code & ~bit_mask);
    wire [9:0] dac_step    = (bit_idx_reg == bit_low) ? dac_decided
                                                      : (dac_decided | (bit_mask >> 1));

    // Read data and interrupt status.
    wire [1:0]  irq_set = {conv_done, seq_done};
    wire [1:0]  irq_clr = (wr_fire & sel_is) ? pwdata[1:0] : 2'h0;
    wire [15:0] status_word = {scf_reg, (st_reg != adcsc_pkg::ST_IDLE), 3'h0, ptr_reg, ccf_reg};
    wire [31:0] rd_mux = sel_c3  ? {24'h000000, ctrl_three_reg} :
                         sel_cr  ? {24'h000000, clock_res_reg} :
                         sel_sq  ? {24'h000000, seq_ctrl_reg} :
                         sel_st  ? {16'h0000, status_word} :
                         sel_is  ? {30'h00000000, irq_status_reg} :
                         sel_im  ? {30'h00000000, irq_mask_reg} :
                         sel_res ? {22'h000000, mem_rdata} : 32'h00000000;

    adcsc_prescaler u_prescaler (
        .clk      (clk),
        .reset    (reset),
        .restart  (restart), // see R19
        .prescale (prescale), // see R7 see R8
        .tick     (tick)
    );

    adcsc_result_mem u_result_mem (
        .clk   (clk),
        .we    (conv_done),
        .waddr (ptr_reg), // see R13 see R14
        .wdata (dac_decided),
        .raddr (paddr[4:2]),
        .rdata (mem_rdata)
    );

    always_comb
    begin
        st_next = st_reg;
        if (restart)
        begin
            st_next = adcsc_pkg::ST_BUF; // see R1 see R2
        end
        else
        begin
            unique case (st_reg)
                adcsc_pkg::ST_IDLE:  st_next = adcsc_pkg::ST_IDLE;
                adcsc_pkg::ST_BUF:   st_next = phase_done ? adcsc_pkg::ST_XFER : st_reg;
                adcsc_pkg::ST_XFER:  st_next = phase_done ? adcsc_pkg::ST_FINAL : st_reg; // see R6
                adcsc_pkg::ST_FINAL: st_next = phase_done ? adcsc_pkg::ST_CONV : st_reg;
                adcsc_pkg::ST_CONV:
                begin
                    if (seq_done && !scan_mode)
                    begin
                        st_next = adcsc_pkg::ST_IDLE; // see R15
                    end
                    else if (conv_done)
                    begin
                        st_next = adcsc_pkg::ST_BUF; // see R15
                    end
                end
                default: st_next = adcsc_pkg::ST_IDLE;
            endcase
        end
    end

    // APB answer: one wait state, data and error on the pready cycle.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= access_first;
            prdata  <= (access_first & ~pwrite) ? rd_mux : 32'h00000000;
            pslverr <= access_first & ~mapped;
        end
    end

    // Software registers.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_three_reg <= adcsc_pkg::CTRL_THREE_RESET;
            clock_res_reg  <= adcsc_pkg::CLOCK_RES_RESET; // see R9
            seq_ctrl_reg   <= adcsc_pkg::SEQ_CTRL_RESET;
            irq_mask_reg   <= 2'h0;
            irq_status_reg <= 2'h0;
            irq            <= 1'b0;
        end
        else
        begin
            if (wr_fire && sel_c3)
            begin
                ctrl_three_reg <= pwdata[7:0] & adcsc_pkg::CTRL_THREE_MASK;
            end
            if (wr_clock_res)
            begin
                clock_res_reg <= pwdata[7:0];
            end
            if (wr_fire && sel_im)
            begin
                irq_mask_reg <= pwdata[1:0];
            end
            seq_ctrl_reg   <= seq_next;
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
            irq            <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Sequencer state and counters.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_reg        <= adcsc_pkg::ST_IDLE;
            phase_cnt_reg <= 5'h00;
            bit_idx_reg   <= adcsc_pkg::BIT_MSB;
            afe_dac_code  <= 10'h000;
            conv_cnt_reg  <= 3'h0;
            ptr_reg       <= 3'h0; // see R18
            afe_channel   <= 3'h0;
            scf_reg       <= 1'b0;
            ccf_reg       <= 8'h00;
        end
        else
        begin
            st_reg <= st_next;
            if (restart || phase_done)
            begin
                phase_cnt_reg <= 5'h00; // see R19
            end
            else if (tick && in_phase)
            begin
                phase_cnt_reg <= phase_cnt_reg + 5'h01;
            end
            if (st_next == adcsc_pkg::ST_CONV && st_reg != adcsc_pkg::ST_CONV)
            begin
                bit_idx_reg  <= adcsc_pkg::BIT_MSB;
                afe_dac_code <= adcsc_pkg::DAC_FIRST;
            end
            else if (tick && st_reg == adcsc_pkg::ST_CONV && !restart)
            begin
                bit_idx_reg  <= bit_idx_reg - 4'h1; // see R4
                afe_dac_code <= dac_step;
            end
            if (restart || seq_done)
            begin
                conv_cnt_reg <= 3'h0;
            end
            else if (conv_done)
            begin
                conv_cnt_reg <= conv_cnt_reg + 3'h1;
            end
            if ((restart || seq_done) && !fifo_mode)
            begin
                ptr_reg <= 3'h0; // see R18
            end
            else if (conv_done)
            begin
                ptr_reg <= ptr_reg + 3'h1; // see R14
            end
            if (restart || (seq_done && scan_mode))
            begin
                afe_channel <= seq_next[2:0]; // see R16
            end
            else if (conv_done && multi_sel)
            begin
                afe_channel <= afe_channel + 3'h1; // see R16 see R17
            end
            scf_reg <= restart ? 1'b0 : (scf_reg | seq_done); // see R2 see R15
            ccf_reg <= restart ? 8'h00 : (ccf_reg | ({7'h00, conv_done} << ptr_reg)); // see R2
        end
    end

    // Analog phase strobes follow the next state.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            afe_buffered_sample <= 1'b0;
            afe_transfer        <= 1'b0;
            afe_direct_sample   <= 1'b0;
            afe_special         <= 1'b0;
        end
        else
        begin
            afe_buffered_sample <= (st_next == adcsc_pkg::ST_BUF);
            afe_transfer        <= (st_next == adcsc_pkg::ST_XFER);
            afe_direct_sample   <= (st_next == adcsc_pkg::ST_FINAL); // see R6
            afe_special         <= seq_next[adcsc_pkg::SQ_SPECIAL];
        end
    end

    // Cycles since the last converter tick, for checking only.
    logic [6:0] gap_cnt_reg;
    logic       gap_valid_reg;
    always_ff @(posedge clk)
    begin
        if (reset || restart)
        begin
            gap_cnt_reg   <= 7'h00;
            gap_valid_reg <= 1'b0;
        end
        else
        begin
            gap_cnt_reg   <= tick ? 7'h00 : gap_cnt_reg + 7'h01;
            gap_valid_reg <= gap_valid_reg | tick;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_clock_res_restart; // see R1
        wr_clock_res |=> (st_reg == adcsc_pkg::ST_BUF) && (phase_cnt_reg == 5'h00);
    endproperty
    a_clock_res_restart: assert property (p_clock_res_restart) else $error("no restart");
    property p_seq_restart_clears; // see R2
        wr_seq |=> !scf_reg && (ccf_reg == 8'h00) && (st_reg == adcsc_pkg::ST_BUF);
    endproperty
    a_seq_restart_clears: assert property (p_seq_restart_clears) else $error("flags kept");
    property p_eight_bit_low; // see R3
        (st_reg == adcsc_pkg::ST_CONV) && !res_ten |-> afe_dac_code[1:0] == 2'h0;
    endproperty
    a_eight_bit_low: assert property (p_eight_bit_low) else $error("low bits used");
    property p_final_exit; // see R5
        (st_reg == adcsc_pkg::ST_FINAL) && tick && (phase_cnt_reg == final_last) && !restart
            |=> st_reg == adcsc_pkg::ST_CONV;
    endproperty
    a_final_exit: assert property (p_final_exit) else $error("final phase length");
    property p_direct_after_transfer; // see R6
        $rose(afe_direct_sample) |-> $past(afe_transfer) || $past(restart);
    endproperty
    a_direct_after_transfer: assert property (p_direct_after_transfer) else $error("bad order");
    property p_tick_period; // see R8
        tick && gap_valid_reg |-> gap_cnt_reg == {1'b0, prescale, 1'b1};
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period");
    property p_prescale_reset; // see R9
        @(posedge clk) disable iff (1'b0) reset |=> clock_res_reg[4:0] == 5'h01;
    endproperty
    a_prescale_reset: assert property (p_prescale_reset) else $error("prescale reset");
    property p_seq_length; // see R11
        seq_done |-> conv_cnt_reg == seq_last;
    endproperty
    a_seq_length: assert property (p_seq_length) else $error("sequence length");
    property p_normal_slot; // see R13
        conv_done && !fifo_mode |-> ptr_reg == conv_cnt_reg;
    endproperty
    a_normal_slot: assert property (p_normal_slot) else $error("result slot");
    property p_scan_next; // see R15
        seq_done |=> (st_reg == (scan_mode ? adcsc_pkg::ST_BUF : adcsc_pkg::ST_IDLE)) && scf_reg;
    endproperty
    a_scan_next: assert property (p_scan_next) else $error("scan handling");
    property p_channel_wrap; // see R17
        conv_done && !seq_done && multi_sel && (afe_channel == 3'h7) |=> afe_channel == 3'h0;
    endproperty
    a_channel_wrap: assert property (p_channel_wrap) else $error("channel wrap");
    property p_ptr_clear; // see R18
        seq_done && !fifo_mode |=> ptr_reg == 3'h0;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

    c_scan_repeat: cover property (seq_done && scan_mode);
    c_fifo_wrap: cover property (conv_done && fifo_mode && ptr_reg == 3'h7);
    c_abort_conv: cover property (restart && st_reg == adcsc_pkg::ST_CONV);
    c_eight_bit_done: cover property (conv_done && !res_ten);
endmodule
`default_nettype wire

/* File: shared/adcsc_pkg.sv */
// Purpose: Constants and types of the converter clock and sequence control block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Tick counts are in converter clock periods.
`default_nettype none
package adcsc_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL_THREE  = 8'h00;
    localparam logic [7:0] OFS_CLOCK_RES   = 8'h04;
    localparam logic [7:0] OFS_SEQ_CTRL    = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
    localparam logic [2:0] RESULT_PAGE     = 3'h1;
    // Field positions.
    localparam int CT3_LENGTH_ONE = 3;
    localparam int CT3_FIFO       = 2;
    localparam int CR_RESOLUTION  = 7;
    localparam int CR_SMP_LSB     = 5;
    localparam int SQ_LENGTH_EIGHT = 6;
    localparam int SQ_SCAN        = 5;
    localparam int SQ_MULTI       = 4;
    localparam int SQ_SPECIAL     = 3;
    localparam int ST_SCF         = 15;
    localparam int ST_BUSY        = 14;
    localparam int ST_PTR_LSB     = 8;
    localparam int IRQ_SEQ        = 0;
    localparam int IRQ_CONV       = 1;
    // Writable bit masks and reset values.
    localparam logic [7:0] CTRL_THREE_MASK  = 8'h0C;
    localparam logic [7:0] SEQ_CTRL_MASK    = 8'h7F;
    localparam logic [7:0] CTRL_THREE_RESET = 8'h00;
    localparam logic [7:0] CLOCK_RES_RESET  = 8'h01;
    localparam logic [7:0] SEQ_CTRL_RESET   = 8'h00;
    // Phase lengths in converter clock ticks.
    localparam logic [4:0] BUF_SAMPLE_TICKS = 5'h02;
    localparam logic [4:0] TRANSFER_TICKS   = 5'h02;
    localparam logic [4:0] FINAL_BASE_TICKS = 5'h02;
    // Successive approximation bit range.
    localparam logic [3:0] BIT_MSB      = 4'h9;
    localparam logic [3:0] BIT_LOW_TEN  = 4'h0;
    localparam logic [3:0] BIT_LOW_EIGHT = 4'h2;
    localparam logic [9:0] DAC_FIRST    = 10'h200;
    // Last conversion index of a sequence.
    localparam logic [2:0] LAST_OF_ONE   = 3'h0;
    localparam logic [2:0] LAST_OF_FOUR  = 3'h3;
    localparam logic [2:0] LAST_OF_EIGHT = 3'h7;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_BUF   = 5'b00010,
        ST_XFER  = 5'b00100,
        ST_FINAL = 5'b01000,
        ST_CONV  = 5'b10000
    } adcsc_state_e;
endpackage
`default_nettype wire

/* File: design/adcsc_prescaler.sv */
// Purpose: Modulus prescaler followed by a divide-by-two stage.
// Assumes: prescale changes only together with restart.
// Notes:   tick pulses once every 2*(prescale+1) bus cycles.
`timescale 1ns/1ps
`default_nettype none
module adcsc_prescaler (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Control
    input  wire logic       restart,
    input  wire logic [4:0] prescale,
    // Converter clock tick
    output var  logic       tick
);
    logic [4:0] count_reg;
    logic       half_reg;
    wire        wrap = (count_reg == prescale);

    always_ff @(posedge clk)
    begin
        if (reset || restart)
        begin
            count_reg <= 5'h00;
            half_reg  <= 1'b0;
            tick      <= 1'b0;
        end
        else
        begin
            count_reg <= wrap ? 5'h00 : count_reg + 5'h01;
            half_reg  <= wrap ? ~half_reg : half_reg;
            tick      <= wrap & half_reg;
        end
    end
endmodule
`default_nettype wire

/* File: design/adcsc_result_mem.sv */
// Purpose: Eight result words with one write port and a registered read port.
// Assumes: Read address is presented one cycle before the data is used.
// Notes:   Contents are undefined until first written.
`timescale 1ns/1ps
`default_nettype none
module adcsc_result_mem (
    // Clock
    input  wire logic       clk,
    // Write port
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [9:0] wdata,
    // Read port
    input  wire logic [2:0] raddr,
    output var  logic [9:0] rdata
);
    logic [9:0] mem [0:7];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the converter clock and sequence control block.
// Assumes: One APB request at a time; comparator input held high, so every converted bit is one.
// Notes:   Phase lengths are counted in bus clock cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic r;} adcsc_row_s;
    logic        clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        afe_compare_above;
    logic [2:0]  afe_channel;
    logic [2:0]  phs;
    logic        spc;
    logic [31:0] q;
    logic        err_seen;
    int          errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n;
    int          m;
    int          c8;
    adcsc_row_s  rows [13] = '{
        '{8'h00, 1'b0, 0, 0, 1'b0}, '{8'h04, 1'b0, 0, 1, 1'b0}, '{8'h08, 1'b0, 0, 0, 1'b0},
        '{8'h0C, 1'b0, 0, 0, 1'b0}, '{8'h10, 1'b0, 0, 0, 1'b0}, '{8'h14, 1'b0, 0, 0, 1'b0},
        '{8'h18, 1'b1, 32'hFF, 0, 1'b1}, '{8'h18, 1'b0, 0, 0, 1'b1},
        '{8'h00, 1'b1, 32'hFF, 0, 1'b0}, '{8'h00, 1'b0, 0, 32'h0C, 1'b0},
        '{8'h00, 1'b1, 0, 0, 1'b0}, '{8'h14, 1'b1, 32'hFF, 0, 1'b0}, '{8'h14, 1'b1, 1, 0, 1'b0}};

    adcsc_control dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .afe_compare_above(afe_compare_above),
        .afe_channel(afe_channel), .afe_special(spc), .afe_buffered_sample(phs[2]),
        .afe_transfer(phs[1]), .afe_direct_sample(phs[0]), .afe_dac_code());

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task report_and_stop;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits for the phase to start, then counts the cycles it stays high.
    task automatic len(input int i, output int c);
        c = 0;
        repeat (2000) if (phs[i] !== 1'b1) @(posedge clk);
        while (phs[i] === 1'b1 && c < 2000)
        begin
            c++;
            @(posedge clk);
        end
    endtask

    task automatic wirq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 8000)
        begin
            c++;
            @(posedge clk);
        end
        bus(1'b1, 8'h10, 32'h1);
    endtask

    initial
    begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        afe_compare_above = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i])
        begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            chk(q, rows[i].e);
            chk({31'h0, err_seen}, {31'h0, rows[i].r});
        end
        bus(1'b1, 8'h08, 0);
        len(2, n);
        chk(n, 9);
        // Prescale 24 and 31 keep the converter clock between 500 kHz and 2 MHz.
        // The first phase after a restart is one cycle longer: the tick is registered.
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, 8'h04, (s << 5) | 32'h18);
            len(2, n);
            chk(n, 101);
            len(1, n);
            chk(n, 100);
            len(0, n);
            chk(n, (2 << s) * 50);
        end
        bus(1'b1, 8'h04, 32'h1F);
        len(2, n);
        chk(n, 129);
        bus(1'b1, 8'h00, 32'h08);
        for (int r = 0; r < 2; r++)
        begin
            bus(1'b1, 8'h04, r ? 32'h98 : 32'h18);
            len(0, n);
            wirq(m);
            if (r == 0) c8 = m;
            bus(1'b0, 8'h20, 0);
            chk(q, r ? 32'h3FF : 32'h3FC);
        end
        chk(m - c8, 100);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 0);
        bus(1'b1, 8'h04, 32'h18);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, 8'h00, k[0] ? 32'h08 : 32'h0);
            bus(1'b1, 8'h08, k[1] ? 32'h40 : 32'h0);
            wirq(m);
            bus(1'b0, 8'h0C, 0);
            chk(q, k[1] ? 32'h80FF : k[0] ? 32'h8001 : 32'h800F);
        end
        bus(1'b1, 8'h00, 0);
        for (int k = 0; k < 2; k++)
        begin
            bus(1'b1, 8'h08, k ? 32'h56 : 32'h05);
            for (int j = 0; j < (k ? 8 : 4); j++)
            begin
                len(2, n);
                chk({29'h0, afe_channel}, {29'h0, k ? 3'(6 + j) : 3'h5});
            end
            wirq(m);
        end
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1) repeat (2) len(2, n);
            bus(1'b1, k ? 8'h04 : 8'h08, k ? 32'h18 : 32'h40);
            bus(1'b0, 8'h0C, 0);
            chk(q & 32'hC7FF, 32'h4000);
        end
        wirq(m);
        bus(1'b1, 8'h00, 32'h0C);
        for (int k = 1; k < 3; k++)
        begin
            bus(1'b1, 8'h08, 0);
            wirq(m);
            bus(1'b0, 8'h0C, 0);
            chk(q, 32'h8000 | (k << 8) | (1 << (k - 1)));
        end
        bus(1'b1, 8'h00, 32'h08);
        bus(1'b1, 8'h08, 32'h20);
        wirq(m);
        bus(1'b0, 8'h0C, 0);
        chk({31'h0, q[14]}, 1);
        bus(1'b1, 8'h14, 0);
        repeat (1500) @(posedge clk);
        chk({31'h0, irq}, 0);
        bus(1'b0, 8'h10, 0);
        chk({31'h0, q[0]}, 1);
        bus(1'b1, 8'h14, 1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 1);
        bus(1'b1, 8'h08, 32'h08);
        @(posedge clk);
        chk({31'h0, spc}, 1);
        report_and_stop();
    end
endmodule
`default_nettype wire
